// ---- pkg/itw_regs.vh ----
`ifndef ITW_REGS_VH
`define ITW_REGS_VH
// register offsets (index; byte address is four times this)
`define ITW_IDX_CLK_CTRL 8'h8b
`define ITW_IDX_COUNT 8'h8c
`define ITW_IDX_WD_MODE 8'h8d
`define ITW_IDX_WD_MATCH 8'h8e
`define ITW_IDX_IRQ_STAT 8'h90
`define ITW_IDX_IRQ_MASK 8'h91
`define ITW_IDX_STATUS 8'h92
// interval_clock_control fields
`define ITW_CC_FLAG 7
`define ITW_CC_CLEAR 3
`define ITW_CC_SEL_HI 2
`define ITW_CC_SEL_LO 0
`define ITW_CC_RESET 3'h5
// watchdog_mode fields
`define ITW_WM_ENABLE 7
`define ITW_WM_RSTSEL 6
`define ITW_WM_CLEAR 5
`define ITW_WM_FLAG 0
`define ITW_MATCH_RESET 8'hff
// irq status bits
`define ITW_IRQ_INTERVAL 0
`define ITW_IRQ_WATCHDOG 1
`define ITW_IRQ_WIDTH 2
// timing: core 10 MHz, ring 1 MHz, timer clock 1MHz/256 ~3.9 kHz
`define ITW_CORE_HZ 10000000
`define ITW_RING_HZ 1000000
`define ITW_RING_DIV (`ITW_CORE_HZ / `ITW_RING_HZ)
`define ITW_TCLK_DIV 256
// stabilisation wait in timer overflows
`define ITW_STAB_OVF 8'h01
// reset pulse length in core cycles
`define ITW_RST_CYC 8'h10
`endif

// ---- logic/itw_tick_div.v ----
`timescale 1ns/1ns
`default_nettype none
// free-running divider giving a one-cycle enable every DIV input enables
module itw_tick_div #(
   parameter integer DIV = 10,
   parameter integer W = 9
) (
   input wire clk,
   input wire rst,
   input wire en_in,
   output reg tick
);
   reg [W-1:0] cnt_reg;
   always @(posedge clk) begin
      if (rst) begin
         cnt_reg <= {W{1'b0}};
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (en_in) begin
            if (cnt_reg == DIV[W-1:0] - 1'b1) begin
               cnt_reg <= {W{1'b0}};
               tick <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 1'b1;
            end
         end
      end
   end
endmodule // itw_tick_div
`default_nettype wire

// ---- logic/itw_top.v ----
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "itw_regs.vh"
// Contract
// - 8-bit interval counter always runs; no setting stops it.
// - writing interval clear zeroes counter; clear bit self-clears next cycle.
// - interval flag set on interval interrupt, stays until written zero.
// - 3-bit select gives overflow periods 0.512 ms to 65.536 ms; reset 101.
// - interval counter readable, read-only, resets to zero.
// - interval timer times clock stabilisation after power-on and stop exit.
// - watchdog counts interval overflows only while enabled.
// - bit 6 of mode selects interrupt timer or CPU reset on match.
// - writing mode bit 5 zeroes watchdog counter; bit self-clears.
// - counter equal to match value raises interrupt or reset request.
// - watchdog period is overflow period times match value plus one.
// - watchdog flag set on interrupt, cleared by zero write or acknowledge.
// - match register write-only and live count read share one address.
// - timers run from a 1 MHz ring-rate time base.
module itw_top (
   input wire CORE_CLK,
   input wire RST,
   input wire [9:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output reg AVS_WAITREQUEST,
   input wire STOP_EXIT,
   input wire INT_ACK,
   output reg WD_IRQ,
   output reg INTERVAL_IRQ,
   output reg CPU_RESET_REQ,
   output reg CLOCK_STABLE,
   output reg IRQ
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ANS = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   wire ring_tick;
   wire tclk_tick;
   reg [2:0] bus_state_reg;
   reg [2:0] bus_state_next;
   wire [7:0] ovf_mask;
   reg [7:0] count_reg;
   reg [2:0] sel_reg;
   reg iflag_reg;
   reg iclear_reg;
   reg wd_en_reg;
   reg wd_rstsel_reg;
   reg wd_clear_reg;
   reg wd_flag_reg;
   reg [7:0] match_reg;
   reg [7:0] wd_count_reg;
   reg [`ITW_IRQ_WIDTH-1:0] stat_reg;
   reg [`ITW_IRQ_WIDTH-1:0] mask_reg;
   reg [7:0] stab_reg;
   reg [7:0] rst_cnt_reg;
   reg ovf;
   reg wd_match;
   wire [7:0] wr_byte;
   wire [7:0] idx;
   wire acc_wr;
   wire acc_rd;
   reg [7:0] rd_byte;

   assign wr_byte = AVS_WRITEDATA[7:0];
   assign idx = AVS_ADDRESS[9:2];
   assign acc_wr = (bus_state_reg == ST_ANS) && AVS_WRITE
      && AVS_BYTEENABLE[0];
   assign acc_rd = (bus_state_reg == ST_IDLE) && AVS_READ;
   // overflow every 2^(select+1) timer clocks; select 7 wraps to 8'hff
   assign ovf_mask = (8'h02 << sel_reg) - 8'h01;

   // ring-rate time base from the core clock
   itw_tick_div #(.DIV(`ITW_RING_DIV), .W(4)) u_ring (
      .clk(CORE_CLK),
      .rst(RST),
      .en_in(1'b1),
      .tick(ring_tick)
   );
   // timer clock ~3.9 kHz
   itw_tick_div #(.DIV(`ITW_TCLK_DIV), .W(9)) u_tclk (
      .clk(CORE_CLK),
      .rst(RST),
      .en_in(ring_tick),
      .tick(tclk_tick)
   );

   // overflow when the selected low counter bits wrap
   always @* begin
      ovf = tclk_tick && ((count_reg & ovf_mask) == ovf_mask);
   end

   // avalon slave: one wait cycle, answer on the second
   always @* begin
      case (bus_state_reg)
         ST_IDLE: bus_state_next = (AVS_READ || AVS_WRITE) ? ST_ANS
            : ST_IDLE;
         ST_ANS: bus_state_next = ST_DONE;
         ST_DONE: bus_state_next = ST_IDLE;
         default: bus_state_next = ST_IDLE;
      endcase
   end

   always @* begin
      case (idx)
         `ITW_IDX_CLK_CTRL: rd_byte = {iflag_reg, 3'h0, iclear_reg,
            sel_reg};
         `ITW_IDX_COUNT: rd_byte = count_reg;
         `ITW_IDX_WD_MODE: rd_byte = {wd_en_reg, wd_rstsel_reg,
            wd_clear_reg, 4'h0, wd_flag_reg};
         `ITW_IDX_WD_MATCH: rd_byte = wd_count_reg;
         `ITW_IDX_IRQ_STAT: rd_byte = {6'h0, stat_reg};
         `ITW_IDX_IRQ_MASK: rd_byte = {6'h0, mask_reg};
         `ITW_IDX_STATUS: rd_byte = {7'h0, CLOCK_STABLE};
         default: rd_byte = 8'h00;
      endcase
   end

   always @* begin
      wd_match = wd_en_reg && ovf && (wd_count_reg == match_reg);
   end

   always @(posedge CORE_CLK) begin
      if (RST) begin
         bus_state_reg <= ST_IDLE;
         AVS_WAITREQUEST <= 1'b1;
         AVS_READDATA <= 32'h0;
      end else begin
         bus_state_reg <= bus_state_next;
         AVS_WAITREQUEST <= !(bus_state_next == ST_ANS);
         if (acc_rd) begin
            AVS_READDATA <= {24'h0, rd_byte};
         end
      end
   end

   // interval timer
   always @(posedge CORE_CLK) begin
      if (RST) begin
         count_reg <= 8'h00;
         sel_reg <= `ITW_CC_RESET;
         iclear_reg <= 1'b0;
         iflag_reg <= 1'b0;
      end else begin
         iclear_reg <= 1'b0;
         if (iclear_reg) begin
            count_reg <= 8'h00;
         end else if (tclk_tick) begin
            count_reg <= count_reg + 8'h01;
         end
         if (acc_wr && idx == `ITW_IDX_CLK_CTRL) begin
            sel_reg <= wr_byte[`ITW_CC_SEL_HI:`ITW_CC_SEL_LO];
            iclear_reg <= wr_byte[`ITW_CC_CLEAR];
            if (!wr_byte[`ITW_CC_FLAG]) begin
               iflag_reg <= 1'b0;
            end
         end
         if (ovf) begin
            iflag_reg <= 1'b1;
         end
      end
   end

   // watchdog
   always @(posedge CORE_CLK) begin
      if (RST) begin
         wd_en_reg <= 1'b0;
         wd_rstsel_reg <= 1'b0;
         wd_clear_reg <= 1'b0;
         wd_flag_reg <= 1'b0;
         match_reg <= `ITW_MATCH_RESET;
         wd_count_reg <= 8'h00;
      end else begin
         wd_clear_reg <= 1'b0;
         if (wd_clear_reg) begin
            wd_count_reg <= 8'h00;
         end else if (wd_match) begin
            wd_count_reg <= 8'h00;
         end else if (wd_en_reg && ovf) begin
            wd_count_reg <= wd_count_reg + 8'h01;
         end
         if (acc_wr && idx == `ITW_IDX_WD_MODE) begin
            wd_en_reg <= wr_byte[`ITW_WM_ENABLE];
            wd_rstsel_reg <= wr_byte[`ITW_WM_RSTSEL];
            wd_clear_reg <= wr_byte[`ITW_WM_CLEAR];
            if (!wr_byte[`ITW_WM_FLAG]) begin
               wd_flag_reg <= 1'b0;
            end
         end
         if (acc_wr && idx == `ITW_IDX_WD_MATCH) begin
            match_reg <= wr_byte;
         end
         if (INT_ACK) begin
            wd_flag_reg <= 1'b0;
         end
         if (wd_match && !wd_rstsel_reg) begin
            wd_flag_reg <= 1'b1;
         end
      end
   end

   // stabilisation wait, cpu reset pulse, interrupt outputs
   always @(posedge CORE_CLK) begin
      if (RST) begin
         stab_reg <= 8'h00;
         CLOCK_STABLE <= 1'b0;
         rst_cnt_reg <= 8'h00;
         CPU_RESET_REQ <= 1'b0;
         stat_reg <= {`ITW_IRQ_WIDTH{1'b0}};
         mask_reg <= {`ITW_IRQ_WIDTH{1'b0}};
         WD_IRQ <= 1'b0;
         INTERVAL_IRQ <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         if (STOP_EXIT) begin
            stab_reg <= 8'h00;
            CLOCK_STABLE <= 1'b0;
         end else if (!CLOCK_STABLE && ovf) begin
            if (stab_reg == `ITW_STAB_OVF - 8'h01) begin
               CLOCK_STABLE <= 1'b1;
            end
            stab_reg <= stab_reg + 8'h01;
         end
         if (wd_match && wd_rstsel_reg) begin
            rst_cnt_reg <= `ITW_RST_CYC;
         end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
         end
         CPU_RESET_REQ <= (rst_cnt_reg != 8'h00);
         if (acc_wr && idx == `ITW_IDX_IRQ_STAT) begin
            stat_reg <= stat_reg & ~wr_byte[`ITW_IRQ_WIDTH-1:0]
               | {wd_match && !wd_rstsel_reg, ovf};
         end else begin
            stat_reg <= stat_reg | {wd_match && !wd_rstsel_reg, ovf};
         end
         if (acc_wr && idx == `ITW_IDX_IRQ_MASK) begin
            mask_reg <= wr_byte[`ITW_IRQ_WIDTH-1:0];
         end
         WD_IRQ <= wd_flag_reg;
         INTERVAL_IRQ <= iflag_reg;
         IRQ <= |(stat_reg & mask_reg);
      end
   end
endmodule // itw_top
`default_nettype wire

// ---- testbench/itw_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module itw_checker (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic INT_ACK,
   input wire logic WD_IRQ,
   input wire logic INTERVAL_IRQ,
   input wire logic CPU_RESET_REQ
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_wait_one: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
      else $error("wait low too long");
   a_req_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |-> ##[1:3] !AVS_WAITREQUEST) else $error("no answer");
   a_data_hold: assert property (!AVS_READ |=> $stable(AVS_READDATA))
      else $error("read data moved");
   a_upper_zero: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
      else $error("upper data set");
   a_reset_len: assert property ($rose(CPU_RESET_REQ) |-> CPU_RESET_REQ[*8]
      ##1 CPU_RESET_REQ[*8] ##1 !CPU_RESET_REQ) else $error("reset length");
   a_iflag_stay: assert property ($fell(INTERVAL_IRQ) |-> $past(AVS_WRITE)
      || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("flag lost");
   a_wflag_stay: assert property ($fell(WD_IRQ) |-> $past(INT_ACK)
      || $past(INT_ACK, 2) || $past(INT_ACK, 3) || $past(AVS_WRITE)
      || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("wd flag lost");
   a_ack_clear: assert property (INT_ACK && WD_IRQ |-> ##[1:3] !WD_IRQ)
      else $error("ack ignored");
   cover property ($rose(WD_IRQ));
   cover property ($rose(CPU_RESET_REQ));
   cover property ($rose(INTERVAL_IRQ));
endmodule // itw_checker
bind itw_top itw_checker itw_checker_i (.CORE_CLK, .RST, .AVS_READ, .AVS_WRITE,
   .AVS_READDATA, .AVS_WAITREQUEST, .INT_ACK, .WD_IRQ, .INTERVAL_IRQ,
   .CPU_RESET_REQ);
`default_nettype wire

// ---- testbench/itw_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module itw_cpu_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic wd_irq,
   input wire logic rst_req,
   input wire logic ack_on,
   output logic int_ack,
   output int resets
);
   // acknowledge pulse on every other cycle while ack_on is set and the interrupt is pending
   always @(posedge clk) begin
      int_ack <= !rst && ack_on && wd_irq && !int_ack;
      if (rst)
         resets <= 0;
      else if (rst_req)
         resets <= resets + 1;
   end
endmodule // itw_cpu_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] addr = 10'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic ack_on = 1'b0;
   logic [31:0] rdata;
   logic wrq, ack, wirq, iirq, rreq, irq, cs;
   logic stp = 1'b0;
   logic [3:0] sig;
   logic [7:0] q;
   int resets, error_cnt = 0, checks = 0;
   time t;
   always #50 clk = ~clk;
   assign sig = {cs, rreq, wirq, iirq};
   itw_top itw_top_i (.CORE_CLK(clk), .RST(rst), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
      .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wrq),
      .STOP_EXIT(stp), .INT_ACK(ack), .WD_IRQ(wirq), .INTERVAL_IRQ(iirq),
      .CPU_RESET_REQ(rreq), .CLOCK_STABLE(cs), .IRQ(irq));
   itw_cpu_model itw_cpu_model_i (.clk(clk), .rst(rst), .wd_irq(wirq),
      .rst_req(rreq), .ack_on(ack_on), .int_ack(ack), .resets(resets));
   task results;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge clk);
      addr <= {idx, 2'b00};
      wr <= w;
      rd <= !w;
      wd <= {24'h0, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wrq !== 1'b0 && n < 20);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      chk(n < 20, 1'b1);
   endtask
   task rdc(input logic [7:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h0);
      chk(q, exp);
   endtask
   task wt(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (sig[s] !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n == lim) begin
         error_cnt++;
         results;
      end
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rdc(8'h8b, 8'h05);
      rdc(8'h8c, 8'h00);
      rdc(8'h8d, 8'h00);
      rdc(8'h99, 8'h00);
      acc(1'b1, 8'h8e, 8'h02);
      rdc(8'h8e, 8'h00);
      acc(1'b1, 8'h8b, 8'h00);
      acc(1'b1, 8'h91, 8'h03);
      $display("registers done");
      wt(0, 1'b1, 20000);
      rdc(8'h8b, 8'h80);
      rdc(8'h90, 8'h01);
      chk(irq, 1'b1);
      acc(1'b1, 8'h90, 8'h01);
      acc(1'b1, 8'h8b, 8'h08);
      rdc(8'h8b, 8'h00);
      rdc(8'h8c, 8'h00);
      chk(irq, 1'b0);
      wt(0, 1'b1, 12000);
      chk(cs, 1'b1);
      @(posedge clk) stp <= 1'b1;
      @(posedge clk) stp <= 1'b0;
      rdc(8'h92, 8'h00);
      wt(3, 1'b1, 12000);
      rdc(8'h92, 8'h01);
      $display("interval done");
      acc(1'b1, 8'h8d, 8'h80);
      wt(1, 1'b1, 40000);
      t = $time;
      rdc(8'h8d, 8'h81);
      rdc(8'h8e, 8'h00);
      chk(irq, 1'b1);
      ack_on <= 1'b1;
      wt(1, 1'b0, 20);
      wt(1, 1'b1, 40000);
      chk((($time - t) / 100), 32'd15360);
      wt(1, 1'b0, 20);
      ack_on <= 1'b0;
      acc(1'b1, 8'h8d, 8'ha0);
      rdc(8'h8d, 8'h80);
      rdc(8'h8e, 8'h00);
      $display("watchdog done");
      acc(1'b1, 8'h8d, 8'hc0);
      wt(2, 1'b1, 40000);
      wt(2, 1'b0, 40);
      chk(resets, 16);
      chk(wirq, 1'b0);
      $display("reset done");
      results;
   end
endmodule // tb_top
`default_nettype wire
